// File: verilog/dodi_top.sv
// The APB interface to the registers and the placing of the registers were decided locally.
`timescale 1ns/100ps
`include "dodi_params.svh"
// Operation
// - Group four lines switch terminal power.
// - Output flip-flop set, reset, hold per digit.
// - Both flip-flop outputs false second half.
// - Printer-punch delay holds 110 ms.
// - Printer-punch delay blocks its next commands.
// - Generator self-resets, rearms after 20 us.
// - Direct and complement delay outputs.
// - Trigger only when true at clock.
// - Interval adjustable six to 200 ms.
// - Group 0 output triggers printer-punch delay.
// - First address bit zero triggers general.
// - Group 1 output triggers typewriter delay.
// - Delays block guarded commands until done.
// - Polarity selects driver, gated by general.
// - True reader input de-energizes, powers reader.
// - Odd time sets polarity, even clears.
// - General delay about 12 ms, holds commands.
module dodi_top #(
  parameter int CYCLES_PER_MS = `DODI_MS_CYC,
  parameter int DIGIT_DIV = `DODI_DIGIT_DIV
) (
  input wire logic CLK_SYS_I,
  input wire logic RESET_I,
  input dodi_pkg::dodi_cmd_s CMD_I,
  input wire logic APB_PSEL_I,
  input wire logic APB_PENABLE_I,
  input wire logic APB_PWRITE_I,
  input wire logic [7:0] APB_PADDR_I,
  input wire logic [31:0] APB_PWDATA_I,
  output logic [31:0] APB_PRDATA_O,
  output logic APB_PREADY_O,
  output logic APB_PSLVERR_O,
  output logic STATE5_INHIBIT_O,
  output logic PRINTER_PUNCH_DELAY_O,
  output logic PRINTER_PUNCH_DELAY_N_O,
  output logic GENERAL_OUTPUT_DELAY_O,
  output logic GENERAL_OUTPUT_DELAY_N_O,
  output logic LOGTYPE_DELAY_O,
  output logic LOGTYPE_DELAY_N_O,
  output logic OUTPUT_POLARITY_FF_O,
  output logic OUTPUT_POLARITY_FF_N_O,
  output logic RELAY_DRV_SET_O,
  output logic RELAY_DRV_CLR_O,
  output logic PP_POWER_O,
  output logic LT_POWER_O,
  output logic READER_RELAY_COIL_O,
  output logic READER_POWER_O
);
  import dodi_pkg::*;

  localparam int CW = $bits(dodi_cmd_s); // Width of the command word.

  // Command word synchroniser stages; stage one feeds stage two only.
  logic [CW-1:0] cmd_s1_r;
  logic [CW-1:0] cmd_s2_r;
  dodi_cmd_s cmd; // Synchronised command seen by the logic.

  // The command arrives from outside this clock, so every bit gets two flops.
  genvar gi;
  generate
    for (gi = 0; gi < CW; gi++) begin : g_sync
      always_ff @(posedge CLK_SYS_I) begin
        if (RESET_I) begin
          cmd_s1_r[gi] <= 1'b0;
          cmd_s2_r[gi] <= 1'b0;
        end else begin
          cmd_s1_r[gi] <= CMD_I[gi];
          cmd_s2_r[gi] <= cmd_s1_r[gi];
        end
      end
    end
  endgenerate
  assign cmd = dodi_cmd_s'(cmd_s2_r);

  // Command decode terms.
  logic in_state5; // Sequencer is in state 5.
  logic dout_op; // A digital output command is decoded.
  logic addr_pp; // Group 0, the printer-punch terminal.
  logic addr_lt; // Group 1, the logging typewriter.
  logic addr_pwr; // Group 4, the power switching group.
  logic addr_low; // First address bit is zero.
  logic pp_trig; // Trigger for the printer-punch delay.
  logic go_trig; // Trigger for the general output delay.
  logic lt_trig; // Trigger for the typewriter delay.

  // Decode of the state, opcode and group address bits.
  always_comb begin
    in_state5 = cmd.seq_state_bit == `DODI_STATE5;
    dout_op = cmd.opcode_bit == `DODI_OP_DOUT;
    addr_pp = cmd.group_addr_bit == `DODI_GRP_PP;
    addr_lt = cmd.group_addr_bit == `DODI_GRP_LT;
    addr_pwr = cmd.group_addr_bit == `DODI_GRP_PWR;
    addr_low = !cmd.group_addr_bit[5];
    pp_trig = in_state5 && dout_op && addr_pp;
    go_trig = in_state5 && dout_op && addr_low;
    lt_trig = in_state5 && dout_op && addr_lt;
  end

  // Register file contents.
  logic reader_r; // Reader relay driver input.
  dodi_len_t pp_len_r; // Printer-punch interval in ms.
  dodi_len_t go_len_r; // General output interval in ms.
  dodi_len_t lt_len_r; // Typewriter interval in ms.
  logic [31:0] status; // Live status word.
  logic pol_q; // Held polarity state, read by the status word and the drivers.

  // APB decode terms.
  logic apb_setup; // Setup cycle of a transfer.
  logic apb_wr; // Write taking effect this edge.
  logic addr_ok; // Address maps to a register.

  always_comb begin
    apb_setup = APB_PSEL_I && !APB_PENABLE_I;
    apb_wr = APB_PSEL_I && APB_PENABLE_I && APB_PREADY_O && APB_PWRITE_I;
    case (APB_PADDR_I & 8'hFC)
      `DODI_OFS_CTRL, `DODI_OFS_PP_LEN, `DODI_OFS_GO_LEN,
      `DODI_OFS_LT_LEN, `DODI_OFS_STATUS: begin
        addr_ok = 1'b1;
      end
      default: begin
        addr_ok = 1'b0;
      end
    endcase
  end

  // Status word, assembled from live block state.
  always_comb begin
    status = 32'h0;
    status[`DODI_ST_PP] = PRINTER_PUNCH_DELAY_O;
    status[`DODI_ST_GO] = GENERAL_OUTPUT_DELAY_O;
    status[`DODI_ST_LT] = LOGTYPE_DELAY_O;
    status[`DODI_ST_POL] = pol_q;
    status[`DODI_ST_INH] = STATE5_INHIBIT_O;
    status[`DODI_ST_PPPWR] = PP_POWER_O;
    status[`DODI_ST_LTPWR] = LT_POWER_O;
  end

  // Every transfer gets exactly one access cycle: ready rises with it.
  // Read data is captured in the setup cycle, a trade of one cycle of
  // status staleness for a registered, glitch-free bus output.
  always_ff @(posedge CLK_SYS_I) begin
    if (RESET_I) begin
      APB_PREADY_O <= 1'b0;
      APB_PSLVERR_O <= 1'b0;
      APB_PRDATA_O <= 32'h0;
    end else begin
      APB_PREADY_O <= apb_setup;
      APB_PSLVERR_O <= apb_setup && !addr_ok;
      if (apb_setup && !APB_PWRITE_I) begin
        case (APB_PADDR_I & 8'hFC)
          `DODI_OFS_CTRL: begin
            APB_PRDATA_O <= {31'h0, reader_r};
          end
          `DODI_OFS_PP_LEN: begin
            APB_PRDATA_O <= {24'h0, pp_len_r};
          end
          `DODI_OFS_GO_LEN: begin
            APB_PRDATA_O <= {24'h0, go_len_r};
          end
          `DODI_OFS_LT_LEN: begin
            APB_PRDATA_O <= {24'h0, lt_len_r};
          end
          `DODI_OFS_STATUS: begin
            APB_PRDATA_O <= status;
          end
          default: begin
            // Unmapped reads return zero with an error.
            APB_PRDATA_O <= 32'h0;
          end
        endcase
      end else if (!APB_PSEL_I) begin
        APB_PRDATA_O <= 32'h0;
      end
    end
  end

  // Writable registers; the status register ignores writes.
  always_ff @(posedge CLK_SYS_I) begin
    if (RESET_I) begin
      reader_r <= 1'b0;
      pp_len_r <= `DODI_PP_LEN_RST;
      go_len_r <= `DODI_GO_LEN_RST;
      lt_len_r <= `DODI_LT_LEN_RST;
    end else if (apb_wr) begin
      case (APB_PADDR_I & 8'hFC)
        `DODI_OFS_CTRL: begin
          reader_r <= APB_PWDATA_I[`DODI_CTRL_READER];
        end
        `DODI_OFS_PP_LEN: begin
          pp_len_r <= APB_PWDATA_I[7:0];
        end
        `DODI_OFS_GO_LEN: begin
          go_len_r <= APB_PWDATA_I[7:0];
        end
        `DODI_OFS_LT_LEN: begin
          lt_len_r <= APB_PWDATA_I[7:0];
        end
        default: begin
          // Read-only or unmapped: nothing stored.
        end
      endcase
    end
  end

  // The three delay generators share one design.
  dodi_delay_gen #(
    .CYC_PER_MS(CYCLES_PER_MS),
    .REC_CYC(`DODI_REC_CYC)
  ) u_pp_dly (
    .clk_i(CLK_SYS_I),
    .rst_i(RESET_I),
    .trig_i(pp_trig),
    .len_i(pp_len_r),
    .active_o(PRINTER_PUNCH_DELAY_O),
    .active_n_o(PRINTER_PUNCH_DELAY_N_O)
  );

  dodi_delay_gen #(
    .CYC_PER_MS(CYCLES_PER_MS),
    .REC_CYC(`DODI_REC_CYC)
  ) u_go_dly (
    .clk_i(CLK_SYS_I),
    .rst_i(RESET_I),
    .trig_i(go_trig),
    .len_i(go_len_r),
    .active_o(GENERAL_OUTPUT_DELAY_O),
    .active_n_o(GENERAL_OUTPUT_DELAY_N_O)
  );

  dodi_delay_gen #(
    .CYC_PER_MS(CYCLES_PER_MS),
    .REC_CYC(`DODI_REC_CYC)
  ) u_lt_dly (
    .clk_i(CLK_SYS_I),
    .rst_i(RESET_I),
    .trig_i(lt_trig),
    .len_i(lt_len_r),
    .active_o(LOGTYPE_DELAY_O),
    .active_n_o(LOGTYPE_DELAY_N_O)
  );

  // Hold off state 5 of any command whose equipment is still timing.
  // The hold depends only on the decoded command, not on state 5, so the
  // sequencer sees it while it still waits in state 4.
  always_ff @(posedge CLK_SYS_I) begin
    if (RESET_I) begin
      STATE5_INHIBIT_O <= 1'b0;
    end else begin
      STATE5_INHIBIT_O <= (PRINTER_PUNCH_DELAY_O && dout_op && addr_pp)
        || (GENERAL_OUTPUT_DELAY_O && dout_op && addr_low)
        || (LOGTYPE_DELAY_O && dout_op && addr_lt);
    end
  end

  // Digit time divider: one enable pulse per digit period.
  logic [7:0] ph_r; // Phase within the digit period.
  logic digit_en; // Last cycle of the digit period.
  logic half; // Second half of the digit period.
  always_ff @(posedge CLK_SYS_I) begin
    if (RESET_I) begin
      ph_r <= 8'h00;
    end else if (digit_en) begin
      ph_r <= 8'h00;
    end else begin
      ph_r <= ph_r + 8'h01;
    end
  end
  assign digit_en = ph_r == 8'(DIGIT_DIV - 1);
  assign half = ph_r >= 8'(DIGIT_DIV / 2);

  // Output polarity flip-flop, set on odd and cleared on even times.
  // Limitation: the command must stay in state 5 across a digit edge.
  dodi_out_ff u_pol_ff (
    .clk_i(CLK_SYS_I),
    .rst_i(RESET_I),
    .digit_en_i(digit_en),
    .half_i(half),
    .set_i(go_trig && cmd.exec_odd),
    .clr_i(go_trig && !cmd.exec_odd),
    .q_o(pol_q),
    .out_o(OUTPUT_POLARITY_FF_O),
    .out_n_o(OUTPUT_POLARITY_FF_N_O)
  );

  // Relay driver pair: polarity picks the side, the general delay gates.
  // Drivers follow the held state so relay current is not chopped.
  always_ff @(posedge CLK_SYS_I) begin
    if (RESET_I) begin
      RELAY_DRV_SET_O <= 1'b0;
      RELAY_DRV_CLR_O <= 1'b0;
    end else begin
      RELAY_DRV_SET_O <= pol_q && GENERAL_OUTPUT_DELAY_O;
      RELAY_DRV_CLR_O <= !pol_q && GENERAL_OUTPUT_DELAY_O;
    end
  end

  // Terminal power lines in group four follow the execution time parity.
  always_ff @(posedge CLK_SYS_I) begin
    if (RESET_I) begin
      PP_POWER_O <= 1'b0;
      LT_POWER_O <= 1'b0;
    end else if (in_state5 && dout_op && addr_pwr) begin
      if (cmd.line_sel[0]) begin
        PP_POWER_O <= cmd.exec_odd;
      end
      if (cmd.line_sel[1]) begin
        LT_POWER_O <= cmd.exec_odd;
      end
    end
  end

  // Reader relay: a true input cuts the coil, which powers the reader.
  always_ff @(posedge CLK_SYS_I) begin
    if (RESET_I) begin
      READER_RELAY_COIL_O <= 1'b1;
      READER_POWER_O <= 1'b0;
    end else begin
      READER_RELAY_COIL_O <= !reader_r;
      READER_POWER_O <= reader_r;
    end
  end

  inhibit_pp_a: assert property (@(posedge CLK_SYS_I) disable iff (RESET_I)
    (PRINTER_PUNCH_DELAY_O && dout_op && addr_pp) |=> STATE5_INHIBIT_O)
    else $error("Printer-punch command not held off.");
  relay_gate_a: assert property (@(posedge CLK_SYS_I) disable iff (RESET_I)
    !$past(GENERAL_OUTPUT_DELAY_O) |-> !RELAY_DRV_SET_O && !RELAY_DRV_CLR_O)
    else $error("Relay driver on without general delay.");
  pp_start_a: assert property (@(posedge CLK_SYS_I) disable iff (RESET_I)
    $rose(PRINTER_PUNCH_DELAY_O) |-> $past(pp_trig))
    else $error("Printer-punch delay started without trigger.");
  go_start_a: assert property (@(posedge CLK_SYS_I) disable iff (RESET_I)
    $rose(GENERAL_OUTPUT_DELAY_O) |-> $past(go_trig))
    else $error("General delay started without trigger.");
  lt_start_a: assert property (@(posedge CLK_SYS_I) disable iff (RESET_I)
    $rose(LOGTYPE_DELAY_O) |-> $past(lt_trig))
    else $error("Typewriter delay started without trigger.");
  reader_pwr_a: assert property (@(posedge CLK_SYS_I) disable iff (RESET_I)
    READER_POWER_O != READER_RELAY_COIL_O)
    else $error("Reader power and coil disagree.");
  pol_set_a: assert property (@(posedge CLK_SYS_I) disable iff (RESET_I)
    (digit_en && go_trig && cmd.exec_odd) |=> pol_q)
    else $error("Odd time did not set polarity.");
  apb_ready_a: assert property (@(posedge CLK_SYS_I) disable iff (RESET_I)
    apb_setup |=> APB_PREADY_O ##1 !APB_PREADY_O)
    else $error("Bus ready not a single access cycle.");
  pp_run_c: cover property (@(posedge CLK_SYS_I) disable iff (RESET_I)
    $fell(PRINTER_PUNCH_DELAY_O));
  inhibit_c: cover property (@(posedge CLK_SYS_I) disable iff (RESET_I)
    $rose(STATE5_INHIBIT_O));
  lt_run_c: cover property (@(posedge CLK_SYS_I) disable iff (RESET_I)
    $rose(LOGTYPE_DELAY_O));
  drv_set_c: cover property (@(posedge CLK_SYS_I) disable iff (RESET_I)
    $rose(RELAY_DRV_SET_O));
endmodule // dodi_top

// File: verilog/dodi_params.svh
`ifndef DODI_PARAMS_SVH
`define DODI_PARAMS_SVH
// System clock rate in MHz (10 ns period).
`define DODI_CLK_MHZ 100
// Cycles in one millisecond, derived from the clock rate.
`define DODI_MS_CYC (`DODI_CLK_MHZ * 1000)
// Recovery time after an interval, in microseconds, and its cycle count.
`define DODI_REC_US 20
`define DODI_REC_CYC (`DODI_REC_US * `DODI_CLK_MHZ)
// Allowed interval range in milliseconds.
`define DODI_LEN_MIN_MS 8'h06
`define DODI_LEN_MAX_MS 8'hC8
// Interval reset values in milliseconds.
`define DODI_PP_LEN_RST 8'h6E
`define DODI_GO_LEN_RST 8'h0C
`define DODI_LT_LEN_RST 8'h6E
// System clocks per digit time of the output flip-flop.
`define DODI_DIGIT_DIV 8
// Sequencer state 5 and digital output opcode codes.
`define DODI_STATE5 3'h3
`define DODI_OP_DOUT 3'h2
// Output groups of interest.
`define DODI_GRP_PP 6'h00
`define DODI_GRP_LT 6'h01
`define DODI_GRP_PWR 6'h04
// Register byte offsets.
`define DODI_OFS_CTRL 8'h00
`define DODI_OFS_PP_LEN 8'h04
`define DODI_OFS_GO_LEN 8'h08
`define DODI_OFS_LT_LEN 8'h0C
`define DODI_OFS_STATUS 8'h10
// Field positions.
`define DODI_CTRL_READER 0
`define DODI_ST_PP 0
`define DODI_ST_GO 1
`define DODI_ST_LT 2
`define DODI_ST_POL 3
`define DODI_ST_INH 4
`define DODI_ST_PPPWR 5
`define DODI_ST_LTPWR 6
`endif

// File: verilog/dodi_pkg.sv
package dodi_pkg;
  // Interval length in milliseconds.
  typedef logic [7:0] dodi_len_t;
  // Delay generator states.
  typedef enum logic [1:0] {
    DODI_IDLE,
    DODI_ACTIVE,
    DODI_RECOVER
  } dodi_dly_e;
  // Command word presented by the sequencer.
  typedef struct packed {
    logic [2:0] seq_state_bit;
    logic [2:0] opcode_bit;
    logic [5:0] group_addr_bit;
    logic exec_odd;
    logic [1:0] line_sel;
  } dodi_cmd_s;
endpackage

// File: verilog/dodi_delay_gen.sv
`timescale 1ns/100ps
`include "dodi_params.svh"
module dodi_delay_gen #(
  parameter int CYC_PER_MS = `DODI_MS_CYC,
  parameter int REC_CYC = `DODI_REC_CYC
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic trig_i,
  input dodi_pkg::dodi_len_t len_i,
  output logic active_o,
  output logic active_n_o
);
  import dodi_pkg::*;
  dodi_dly_e st_r; // Current state.
  logic [31:0] sub_r; // Cycle counter within a millisecond or recovery.
  dodi_len_t ms_r; // Milliseconds left.
  dodi_len_t len_c; // Clamped length.
  // Clamp the length so a bad setting cannot stretch or kill the interval.
  always_comb begin
    if (len_i < `DODI_LEN_MIN_MS) begin
      len_c = `DODI_LEN_MIN_MS;
    end else if (len_i > `DODI_LEN_MAX_MS) begin
      len_c = `DODI_LEN_MAX_MS;
    end else begin
      len_c = len_i;
    end
  end
  // Sequencing of idle, timed interval and recovery.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_r <= DODI_IDLE;
      sub_r <= 32'h0;
      ms_r <= 8'h00;
      active_o <= 1'b0;
      active_n_o <= 1'b1;
    end else begin
      case (st_r)
        DODI_IDLE: begin
          // Only a true trigger at a clock edge starts the interval.
          if (trig_i) begin
            st_r <= DODI_ACTIVE;
            ms_r <= len_c;
            sub_r <= 32'h0;
            active_o <= 1'b1;
            active_n_o <= 1'b0;
          end
        end
        DODI_ACTIVE: begin
          // Triggers here are ignored, so the interval is never lengthened.
          if (sub_r == 32'(CYC_PER_MS - 1)) begin
            sub_r <= 32'h0;
            if (ms_r == 8'h01) begin
              st_r <= DODI_RECOVER;
              active_o <= 1'b0;
              active_n_o <= 1'b1;
            end else begin
              ms_r <= ms_r - 8'h01;
            end
          end else begin
            sub_r <= sub_r + 32'h1;
          end
        end
        DODI_RECOVER: begin
          // Recovery blocks retriggering for the fixed time.
          if (sub_r == 32'(REC_CYC - 1)) begin
            st_r <= DODI_IDLE;
            sub_r <= 32'h0;
          end else begin
            sub_r <= sub_r + 32'h1;
          end
        end
        default: begin
          st_r <= DODI_IDLE;
        end
      endcase
    end
  end
  // Helper counters watched only by the checks below.
  logic [31:0] on_cnt_r;
  logic [31:0] off_cnt_r;
  logic [31:0] len_cyc_r;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      on_cnt_r <= 32'h0;
      off_cnt_r <= 32'hFFFF_FFFF;
      len_cyc_r <= 32'h0;
    end else begin
      on_cnt_r <= active_o ? on_cnt_r + 32'h1 : 32'h0;
      off_cnt_r <= active_o ? 32'h0 : off_cnt_r + ((off_cnt_r == 32'hFFFF_FFFF) ? 32'h0 : 32'h1);
      if (st_r == DODI_IDLE && trig_i) begin
        len_cyc_r <= 32'(len_c) * 32'(CYC_PER_MS);
      end
    end
  end
  dly_length_a: assert property (@(posedge clk_i) disable iff (rst_i)
    $fell(active_o) |-> on_cnt_r == len_cyc_r)
    else $error("Delay interval length wrong.");
  dly_recovery_a: assert property (@(posedge clk_i) disable iff (rst_i)
    $rose(active_o) |-> off_cnt_r >= 32'(REC_CYC))
    else $error("Retriggered inside recovery time.");
  dly_compl_a: assert property (@(posedge clk_i) disable iff (rst_i)
    active_n_o == !active_o)
    else $error("Delay complement output wrong.");
  dly_start_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (st_r == DODI_IDLE && trig_i) |=> active_o)
    else $error("Trigger did not start interval.");
endmodule // dodi_delay_gen

// File: verilog/dodi_out_ff.sv
`timescale 1ns/100ps
module dodi_out_ff (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic digit_en_i,
  input wire logic half_i,
  input wire logic set_i,
  input wire logic clr_i,
  output logic q_o,
  output logic out_o,
  output logic out_n_o
);
  // Stored state, updated only at a digit time.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q_o <= 1'b0;
    end else if (digit_en_i) begin
      if (set_i && !clr_i) begin
        q_o <= 1'b1;
      end else if (clr_i && !set_i) begin
        q_o <= 1'b0;
      end
    end
  end
  // Both sides read false in the second half of the digit period.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      out_o <= 1'b0;
      out_n_o <= 1'b0;
    end else begin
      out_o <= q_o && !half_i;
      out_n_o <= !q_o && !half_i;
    end
  end
  off_half_a: assert property (@(posedge clk_i) disable iff (rst_i)
    $past(half_i) |-> !out_o && !out_n_o)
    else $error("Output flip-flop not false in second half.");
  ff_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !digit_en_i |=> $stable(q_o))
    else $error("Output flip-flop moved outside digit time.");
endmodule // dodi_out_ff

// File: tb/dodi_far_side.sv
`timescale 1ns/100ps
// Far side of the block: one polarized output relay and the tape reader.
module dodi_far_side (
  input wire logic clk_i,
  input wire logic drv_set_i,
  input wire logic drv_clr_i,
  input wire logic reader_power_i,
  output logic relay_o,
  output logic reader_on_o
);
  // The relay is bistable, so its contact holds between driver pulses.
  always_ff @(posedge clk_i) begin
    if (drv_set_i) begin
      relay_o <= 1'b1;
    end else if (drv_clr_i) begin
      relay_o <= 1'b0;
    end
  end
  // The reader runs only while switched power reaches it.
  assign reader_on_o = reader_power_i;
endmodule // dodi_far_side

// File: tb/tb_digital_output_delay_interlock.sv
`timescale 1ns/100ps
`include "dodi_params.svh"
module tb_digital_output_delay_interlock;
  import dodi_pkg::*;
  logic clk, rst, psel, pen, pwr;
  logic [7:0] paddr;
  logic [31:0] pwdata, rd;
  dodi_cmd_s cmd;
  wire ready, slverr, inh, relay, rdr_on;
  wire [31:0] prdata;
  wire [2:0] dly, dly_n; // Index 0 printer-punch, 1 general, 2 typewriter.
  wire [1:0] pol, drv, tpwr, rdr;
  int err_count = 0;
  int cmp_count = 0;
  int cyc = 0;
  int golen, grp, q, r;
  logic e;
  // Short millisecond keeps intervals at 60 to 2000 cycles.
  dodi_top #(.CYCLES_PER_MS(10), .DIGIT_DIV(8)) DUT (
    .CLK_SYS_I(clk), .RESET_I(rst), .CMD_I(cmd),
    .APB_PSEL_I(psel), .APB_PENABLE_I(pen), .APB_PWRITE_I(pwr),
    .APB_PADDR_I(paddr), .APB_PWDATA_I(pwdata), .APB_PRDATA_O(prdata),
    .APB_PREADY_O(ready), .APB_PSLVERR_O(slverr), .STATE5_INHIBIT_O(inh),
    .PRINTER_PUNCH_DELAY_O(dly[0]), .PRINTER_PUNCH_DELAY_N_O(dly_n[0]),
    .GENERAL_OUTPUT_DELAY_O(dly[1]), .GENERAL_OUTPUT_DELAY_N_O(dly_n[1]),
    .LOGTYPE_DELAY_O(dly[2]), .LOGTYPE_DELAY_N_O(dly_n[2]),
    .OUTPUT_POLARITY_FF_O(pol[1]), .OUTPUT_POLARITY_FF_N_O(pol[0]),
    .RELAY_DRV_SET_O(drv[1]), .RELAY_DRV_CLR_O(drv[0]),
    .PP_POWER_O(tpwr[0]), .LT_POWER_O(tpwr[1]),
    .READER_RELAY_COIL_O(rdr[1]), .READER_POWER_O(rdr[0])
  );
  dodi_far_side u_far (
    .clk_i(clk), .drv_set_i(drv[1]), .drv_clr_i(drv[0]),
    .reader_power_i(rdr[0]), .relay_o(relay), .reader_on_o(rdr_on)
  );
  // Free-running 100 MHz clock.
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // Hang guard, well above the longest expected run.
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      err_count++;
      test_done();
    end
  end
  // Prints the counts and the verdict, then stops.
  task automatic test_done();
    $display("compares %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask
  // One APB transfer; entered just after a rising edge.
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwr <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    // Only the bench's hang guard ends this wait.
    do begin
      @(posedge clk);
    end while (ready !== 1'b1);
    rd = prdata;
    e = slverr;
    psel <= 1'b0;
    pen <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] exp, input logic eexp);
    apb(1'b0, a, 32'h00000000);
    chk(rd, exp);
    chk(e, eexp);
  endtask
  // Expected interval in cycles: length is clamped into 6..200 ms.
  function automatic int len_cyc(input int ms);
    return 10 * (ms < 6 ? 6 : (ms > 200 ? 200 : ms));
  endfunction
  function automatic dodi_cmd_s mk(input logic [5:0] g, input logic odd, input logic [1:0] ln);
    mk = '{`DODI_STATE5, `DODI_OP_DOUT, g, odd, ln};
  endfunction
  // Holds a command, times generator i, and checks that holding the
  // command for 500 cycles into the 2000-cycle recovery window does not fire it again.
  task automatic fire(input logic [5:0] g, input int i, input int exp, input logic [6:0] sx);
    logic [6:0] s;
    int n;
    n = 0;
    r = 0;
    s = '0;
    cmd <= mk(g, 1'b0, 2'b00);
    while (dly[i] !== 1'b1 && n < 3000) begin
      @(negedge clk);
      n++;
    end
    n = 0;
    while (dly[i] === 1'b1 && n < 3000) begin
      if (n == 2) s = {inh, dly, dly_n};
      @(negedge clk);
      n++;
    end
    repeat (500) begin
      @(negedge clk);
      r += dly[i];
    end
    chk(n, exp);
    chk(r, 0);
    chk(s, sx);
    @(posedge clk);
    cmd <= '0;
    repeat (4100) @(posedge clk);
  endtask
  initial begin
    rst = 1'b1;
    psel = 1'b0;
    pen = 1'b0;
    pwr = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h00000000;
    cmd = '0;
    void'($urandom(32'habfeaf5b));
    golen = 4 + $urandom % 200;
    grp = 2 + $urandom % 30;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    repeat (3) @(posedge clk);
    chk({inh, dly, dly_n, pol, drv, tpwr, rdr}, 15'h0742);
    rchk(`DODI_OFS_CTRL, 32'h00000000, 1'b0);
    rchk(`DODI_OFS_PP_LEN, 32'h0000006E, 1'b0);
    rchk(`DODI_OFS_GO_LEN, 32'h0000000C, 1'b0);
    rchk(`DODI_OFS_LT_LEN, 32'h0000006E, 1'b0);
    rchk(8'h14, 32'h00000000, 1'b1);
    apb(1'b1, `DODI_OFS_STATUS, 32'h000000FF);
    rchk(`DODI_OFS_STATUS, 32'h00000000, 1'b0);
    // Below-minimum length and a random general length.
    apb(1'b1, `DODI_OFS_PP_LEN, 32'h00000003);
    apb(1'b1, `DODI_OFS_GO_LEN, 32'(golen));
    rchk(`DODI_OFS_GO_LEN, 32'(golen), 1'b0);
    fire(`DODI_GRP_PP, 0, len_cyc(3), 7'b1011100);
    fire(`DODI_GRP_LT, 2, len_cyc(110), 7'b1110001);
    fire(6'(grp), 1, len_cyc(golen), 7'b1010101);
    // First address bit set: nothing may fire.
    cmd <= mk(6'h20 | 6'($urandom % 32), 1'b0, 2'b00);
    r = 0;
    repeat (100) begin
      @(negedge clk);
      r += |dly;
    end
    chk(r, 0);
    @(posedge clk);
    cmd <= '0;
    @(posedge clk);
    // Odd then even execution time; flip-flop shows 4 of 8 cycles.
    for (int k = 1; k >= 0; k--) begin
      cmd <= mk(6'h02, k[0], 2'b00);
      repeat (12) @(posedge clk);
      cmd <= '0;
      q = 0;
      r = 0;
      repeat (8) begin
        @(negedge clk);
        q += pol[1];
        r += pol[0];
      end
      chk(q, k ? 4 : 0);
      chk(r, k ? 0 : 4);
      chk({drv, relay}, k ? 3'b101 : 3'b010);
      @(posedge clk);
      // Status shows the general delay still running and the held polarity.
      rchk(`DODI_OFS_STATUS, k ? 32'h0000000A : 32'h00000002, 1'b0);
    end
    // Group four lines one and two switch terminal power.
    for (int k = 0; k < 3; k++) begin
      cmd <= mk(`DODI_GRP_PWR, k < 2, 2'(k + 1));
      repeat (4) @(posedge clk);
      cmd <= '0;
      repeat (4) @(posedge clk);
      chk(tpwr, k == 0 ? 2'b01 : (k == 1 ? 2'b11 : 2'b00));
    end
    // A true drive input releases the coil and powers the reader.
    for (int k = 1; k >= 0; k--) begin
      apb(1'b1, `DODI_OFS_CTRL, 32'(k));
      repeat (3) @(posedge clk);
      chk({rdr, rdr_on}, k ? 3'b011 : 3'b100);
      rchk(`DODI_OFS_CTRL, 32'(k), 1'b0);
    end
    test_done();
  end
endmodule // tb_digital_output_delay_interlock
